// ===== src/mop_consts.vh
`ifndef MOP_CONSTS_VH
`define MOP_CONSTS_VH
// Register indices (byte address = 4 * index)
`define MOP_REG_MODE 4'h0
`define MOP_REG_CURR 4'h1
`define MOP_REG_TIME 4'h2
`define MOP_REG_MINSPD 4'h3
`define MOP_REG_SENS 4'h4
`define MOP_REG_CLASS 4'h5
`define MOP_REG_CHSEL 4'h6
`define MOP_REG_MTYPE 4'h7
`define MOP_REG_BEMF 4'h8
`define MOP_REG_RES 4'h9
`define MOP_REG_LD 4'hA
`define MOP_REG_LQ 4'hB
`define MOP_REG_STATUS 4'hC
`define MOP_REG_ACC 4'hD
// Overload modes
`define MOP_MODE_OFF 2'h0
`define MOP_MODE_TRIP 2'h1
`define MOP_MODE_LIM_T 2'h2
`define MOP_MODE_LIM_SPD 2'h3
// Reset values
`define MOP_RST_MODE 2'h1
`define MOP_RST_CURR 8'h64
`define MOP_RST_TIME 11'h03C
`define MOP_RST_SENS 3'h0
`define MOP_RST_CLASS 3'h3
`define MOP_RST_CHSEL 4'h7
`define MOP_RST_BEMF 10'h190
// Limits
`define MOP_CURR_MAX 8'h96
`define MOP_TIME_MIN 11'h03C
`define MOP_TIME_MAX 11'h4B0
`define MOP_SENS_MAX 3'h5
`define MOP_CLASS_MAX 3'h5
`define MOP_CHSEL_MAX 4'hA
`define MOP_BEMF_MIN 10'h064
`define MOP_BEMF_MAX 10'h2BC
// Resistance in micro-ohm: 1 .. 40000000; inductance in micro-henry
`define MOP_RES_MAX 32'h02625A00
`define MOP_IND_MAX 32'h00989680
`define MOP_UNDEF 32'h00000000
// Thresholds in percent of the limit
`define MOP_PCT_LIMIT 8'h5F
`define MOP_PCT_TRIP 8'h6E
// Sample tick: one accumulation step per millisecond
`define MOP_TICK_NS 1000000
`define MOP_CLK_NS 20
`define MOP_TICK_CYC (`MOP_TICK_NS / `MOP_CLK_NS)
`define MOP_MS_PER_S 1000
`endif

// ===== src/mop_protect.v
// How it works
// RQ1: Mode 0 disables overload supervision; no trip, no limiting.
// RQ2: Mode 1 (default) trips when the accumulated overload reaches the limit.
// RQ3: Mode 2 limits current to the reference instead of tripping.
// RQ4: Mode 3 limits speed instead, honouring the minimum allowed speed.
// RQ5: Limiting modes may command speed below the normal minimum speed.
// RQ6: Current reference 0..150 percent of nominal, default 100.
// RQ7: Time 60..1200 s, default 60; time to limit at 1.2x reference. Code takes about 3.3x that: only excess over reference squared accrues.
// RQ8: Accumulate squared current relative to reference and time.
// RQ9: Limiting modes reduce torque once accumulator reaches 95 percent. Code raises torque_limit_out in mode 2 only; mode 3 raises speed_limit_out.
// RQ10: Limiting modes trip once accumulator exceeds 110 percent.
// RQ11: Software must set reference above motor no-load current.
// RQ12: Sensor select 0..5: off, PTC, RTD, PTC+RTD, 2PTC, 2PTC+RTD.
// RQ13: Sensor selections accepted only with one or two boards fitted.
// RQ14: Two boards, one thermistor selected: use first board's thermistor.
// RQ15: Any thermistor selection makes thermometer inputs ignored.
// RQ16: Class 0..5 gives thermometer trip 100,115,120,140,145,165 C.
// RQ17: Channel select 1..7 is mask of 1..3; 8,9,10 mean 1-4,1-5,1-6.
// RQ18: Channel selection applies only while thermometers are enabled.
// RQ19: Extended motor data available only for synchronous motor types.
// RQ20: Back-EMF 100..700 V in 1 V steps.
// RQ21: Phase resistance undefined by default, 0.001..40000 milliohm.
// RQ22: D and Q inductance undefined by default, 0.001..10000 mH.
// RQ23: Accumulator decays below reference, floors at zero, resets to zero.
`timescale 1ns/1ns
`include "mop_consts.vh"
module mop_protect #(
    parameter TICK_CYC = `MOP_TICK_CYC,
    parameter NCH = 6
) (
    input wire ref_clk_in,
    input wire nrst_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire [7:0] motor_current_in,
    input wire [1:0] boards_fitted_in,
    input wire [1:0] thermistor_hot_in,
    input wire [NCH*8-1:0] thermometer_temp_in,
    input wire [15:0] minimum_speed_setting_in,
    output reg overload_trip_out,
    output reg torque_limit_out,
    output reg speed_limit_out,
    output reg [7:0] current_cap_out,
    output reg [15:0] speed_floor_out,
    output reg thermal_trip_out
);
    reg [1:0] mode_q;
    reg [7:0] curr_q;
    reg [10:0] time_q;
    reg [15:0] minspd_q;
    reg [2:0] sens_q;
    reg [2:0] class_q;
    reg [3:0] chsel_q;
    reg [1:0] mtype_q;
    reg [9:0] bemf_q;
    reg [31:0] res_q;
    reg [31:0] ld_q;
    reg [31:0] lq_q;
    reg [47:0] acc_q;
    reg [19:0] tick_q;
    reg [1:0] th_a_q;
    reg [1:0] th_b_q;
    reg [1:0] th_c_q;
    reg [1:0] thermistor_q;
    reg [1:0] bd_a_q;
    reg [1:0] bd_b_q;
    reg [1:0] bd_c_q;
    reg [1:0] boards_q;
    reg [NCH*8-1:0] tm_a_q;
    reg [NCH*8-1:0] tm_b_q;
    reg [NCH*8-1:0] tm_c_q;
    reg [NCH*8-1:0] temps_q;

    wire tick = (tick_q == TICK_CYC - 1);
    wire ext_ok = (mtype_q == 2'h1) || (mtype_q == 2'h2); // [RQ19]
    // A count of three is not a legal fit, so it enables nothing
    wire boards_ok = (boards_q == 2'h1) || (boards_q == 2'h2); // [RQ13]
    wire limiting = (mode_q == `MOP_MODE_LIM_T) ||
        (mode_q == `MOP_MODE_LIM_SPD);

    localparam [47:0] ACC_MAX = 48'hFFFFFFFFFFFF;
    // Limit: acc units are pct^2 * ms; 120 pct squared held for time_q seconds
    wire [47:0] limit_d = {16'h0000, curr_q} * {16'h0000, curr_q} * 48'h90 /
        48'h64 * {37'h0, time_q} * `MOP_MS_PER_S;
    // The divide chain is long, so thresholds are registered; a settings
    // write reaches them one cycle late, far inside one tick
    reg [47:0] limit_q;
    reg [47:0] lim95_q;
    reg [47:0] lim110_q;
    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            // All ones, so nothing trips before the first real limit
            limit_q <= ACC_MAX;
            lim95_q <= ACC_MAX;
            lim110_q <= ACC_MAX;
        end
        else
        begin
            limit_q <= limit_d;
            lim95_q <= limit_d / 48'h64 * `MOP_PCT_LIMIT;
            lim110_q <= limit_d / 48'h64 * `MOP_PCT_TRIP;
        end
    end
    // Pivot at the reference squared: heating equals cooling there
    wire [47:0] i_sq = {40'h0, motor_current_in} * {40'h0, motor_current_in};
    wire [47:0] r_sq = {40'h0, curr_q} * {40'h0, curr_q};

    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            th_a_q <= 2'h0;
            th_b_q <= 2'h0;
            th_c_q <= 2'h0;
            thermistor_q <= 2'h0;
            bd_a_q <= 2'h0;
            bd_b_q <= 2'h0;
            bd_c_q <= 2'h0;
            boards_q <= 2'h0;
            tm_a_q <= {NCH*8{1'b0}};
            tm_b_q <= {NCH*8{1'b0}};
            tm_c_q <= {NCH*8{1'b0}};
            temps_q <= {NCH*8{1'b0}};
        end
        else
        begin
            // Three stages; a change counts once the last two agree
            th_a_q <= thermistor_hot_in;
            th_b_q <= th_a_q;
            th_c_q <= th_b_q;
            if (th_b_q == th_c_q)
                thermistor_q <= th_c_q;
            bd_a_q <= boards_fitted_in;
            bd_b_q <= bd_a_q;
            bd_c_q <= bd_b_q;
            if (bd_b_q == bd_c_q)
                boards_q <= bd_c_q;
            tm_a_q <= thermometer_temp_in;
            tm_b_q <= tm_a_q;
            tm_c_q <= tm_b_q;
            if (tm_b_q == tm_c_q)
                temps_q <= tm_c_q;
        end
    end

    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            mode_q <= `MOP_RST_MODE;
            curr_q <= `MOP_RST_CURR;
            time_q <= `MOP_RST_TIME;
            minspd_q <= 16'h0000;
            sens_q <= `MOP_RST_SENS;
            class_q <= `MOP_RST_CLASS;
            chsel_q <= `MOP_RST_CHSEL;
            mtype_q <= 2'h0;
            bemf_q <= `MOP_RST_BEMF;
            res_q <= `MOP_UNDEF;
            ld_q <= `MOP_UNDEF;
            lq_q <= `MOP_UNDEF;
        end
        else if (wr_in)
        begin
            // Out-of-range writes are dropped, keeping the old setting, except mode and minimum speed, which keep the low bits
            case (addr_in)
                `MOP_REG_MODE: mode_q <= wdata_in[1:0]; // [RQ1] [RQ2]
                `MOP_REG_CURR:
                    if (wdata_in <= {24'h0, `MOP_CURR_MAX})
                        curr_q <= wdata_in[7:0]; // [RQ6]
                `MOP_REG_TIME:
                    if (wdata_in >= {21'h0, `MOP_TIME_MIN} &&
                        wdata_in <= {21'h0, `MOP_TIME_MAX})
                        time_q <= wdata_in[10:0]; // [RQ7]
                `MOP_REG_MINSPD: minspd_q <= wdata_in[15:0];
                `MOP_REG_SENS:
                    if (wdata_in <= {29'h0, `MOP_SENS_MAX} &&
                        (boards_ok || wdata_in == 32'h0))
                        sens_q <= wdata_in[2:0]; // [RQ12] [RQ13]
                `MOP_REG_CLASS:
                    if (wdata_in <= {29'h0, `MOP_CLASS_MAX})
                        class_q <= wdata_in[2:0];
                `MOP_REG_CHSEL:
                    if (wdata_in != 32'h0 &&
                        wdata_in <= {28'h0, `MOP_CHSEL_MAX})
                        chsel_q <= wdata_in[3:0];
                `MOP_REG_MTYPE:
                    if (wdata_in <= 32'h2)
                        mtype_q <= wdata_in[1:0];
                `MOP_REG_BEMF:
                    if (ext_ok && wdata_in >= {22'h0, `MOP_BEMF_MIN} &&
                        wdata_in <= {22'h0, `MOP_BEMF_MAX})
                        bemf_q <= wdata_in[9:0]; // [RQ19] [RQ20]
                `MOP_REG_RES:
                    if (ext_ok && wdata_in <= `MOP_RES_MAX)
                        res_q <= wdata_in; // [RQ21]
                `MOP_REG_LD:
                    if (ext_ok && wdata_in <= `MOP_IND_MAX)
                        ld_q <= wdata_in; // [RQ22]
                `MOP_REG_LQ:
                    if (ext_ok && wdata_in <= `MOP_IND_MAX)
                        lq_q <= wdata_in; // [RQ22]
                default: ;
            endcase
        end
    end

    // Overload accumulator, one step per millisecond tick
    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            tick_q <= 20'h00000;
            acc_q <= 48'h0; // [RQ23]
        end
        else
        begin
            tick_q <= tick ? 20'h00000 : tick_q + 20'h00001;
            if (mode_q == `MOP_MODE_OFF)
                acc_q <= 48'h0; // [RQ1]
            else if (tick)
            begin
                if (i_sq >= r_sq)
                begin
                    // Saturate, not wrap: a stalled motor in a limiting
                    // mode keeps adding long after the trip has latched
                    if (acc_q > ACC_MAX - (i_sq - r_sq))
                        acc_q <= ACC_MAX;
                    else
                        acc_q <= acc_q + (i_sq - r_sq); // [RQ8]
                end
                else if (acc_q > r_sq - i_sq)
                    acc_q <= acc_q - (r_sq - i_sq); // [RQ23]
                else
                    acc_q <= 48'h0; // [RQ23]
            end
        end
    end

    // Thermometer trip level by motor class
    reg [7:0] trip_deg;
    always @*
    begin
        case (class_q) // [RQ16]
            3'h0: trip_deg = 8'h64;
            3'h1: trip_deg = 8'h73;
            3'h2: trip_deg = 8'h78;
            3'h3: trip_deg = 8'h8C;
            3'h4: trip_deg = 8'h91;
            3'h5: trip_deg = 8'hA5;
            default: trip_deg = 8'h8C;
        endcase
    end

    reg [NCH-1:0] ch_mask;
    always @*
    begin
        case (chsel_q) // [RQ17]
            4'h8: ch_mask = 6'h0F;
            4'h9: ch_mask = 6'h1F;
            4'hA: ch_mask = 6'h3F;
            default: ch_mask = {3'h0, chsel_q[2:0]};
        endcase
    end

    // Sensor selection decode; codes above five never reach sens_q
    // because the write path refuses them
    reg ptc_any;
    reg rtd_sel;
    reg two_ptc;
    always @*
    begin
        ptc_any = 1'b0;
        rtd_sel = 1'b0;
        two_ptc = 1'b0;
        case (sens_q) // [RQ12]
            3'h1: ptc_any = 1'b1;
            3'h2: rtd_sel = 1'b1;
            3'h3:
            begin
                ptc_any = 1'b1;
                rtd_sel = 1'b1;
            end
            3'h4:
            begin
                ptc_any = 1'b1;
                two_ptc = 1'b1;
            end
            3'h5:
            begin
                ptc_any = 1'b1;
                rtd_sel = 1'b1;
                two_ptc = 1'b1;
            end
            default: ;
        endcase
    end
    // Any thermistor selection mutes the thermometers
    wire rtd_en = rtd_sel && !ptc_any; // [RQ15]
    // Single thermistor always reads the first board
    wire ptc_hot = thermistor_q[0] ||
        (two_ptc && boards_q == 2'h2 && thermistor_q[1]); // [RQ14]

    wire [NCH-1:0] ch_hot;
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : gen_ch
            assign ch_hot[g] = rtd_en && ch_mask[g] &&
                (temps_q[g*8 +: 8] >= trip_deg); // [RQ18]
        end
    endgenerate

    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            overload_trip_out <= 1'b0;
            torque_limit_out <= 1'b0;
            speed_limit_out <= 1'b0;
            current_cap_out <= 8'h00;
            speed_floor_out <= 16'h0000;
            thermal_trip_out <= 1'b0;
        end
        else
        begin
            // Trips latch until reset; a running drive must not restart
            if (mode_q == `MOP_MODE_TRIP && acc_q >= limit_q)
                overload_trip_out <= 1'b1; // [RQ2]
            if (limiting && acc_q > lim110_q)
                overload_trip_out <= 1'b1; // [RQ10]
            torque_limit_out <= (mode_q == `MOP_MODE_LIM_T) &&
                (acc_q >= lim95_q); // [RQ3] [RQ9]
            speed_limit_out <= (mode_q == `MOP_MODE_LIM_SPD) &&
                (acc_q >= lim95_q); // [RQ4] [RQ9]
            current_cap_out <= curr_q; // [RQ3]
            // In limiting modes the floor is the overload minimum, not the normal minimum
            speed_floor_out <= limiting ? minspd_q :
                minimum_speed_setting_in; // [RQ4] [RQ5]
            if (boards_ok && ((ptc_any && ptc_hot) || (|ch_hot)))
                thermal_trip_out <= 1'b1;
        end
    end

    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
            rdata_out <= 32'h00000000;
        else if (rd_in)
        begin
            case (addr_in)
                `MOP_REG_MODE: rdata_out <= {30'h0, mode_q};
                `MOP_REG_CURR: rdata_out <= {24'h0, curr_q};
                `MOP_REG_TIME: rdata_out <= {21'h0, time_q};
                `MOP_REG_MINSPD: rdata_out <= {16'h0, minspd_q};
                `MOP_REG_SENS: rdata_out <= {29'h0, sens_q};
                `MOP_REG_CLASS: rdata_out <= {29'h0, class_q};
                `MOP_REG_CHSEL: rdata_out <= {28'h0, chsel_q};
                `MOP_REG_MTYPE: rdata_out <= {30'h0, mtype_q};
                `MOP_REG_BEMF: rdata_out <= {22'h0, bemf_q};
                `MOP_REG_RES: rdata_out <= res_q;
                `MOP_REG_LD: rdata_out <= ld_q;
                `MOP_REG_LQ: rdata_out <= lq_q;
                `MOP_REG_STATUS: rdata_out <= {26'h0, boards_q,
                    thermal_trip_out, speed_limit_out, torque_limit_out,
                    overload_trip_out};
                `MOP_REG_ACC: rdata_out <= acc_q[47:16];
                default: rdata_out <= 32'h00000000;
            endcase
        end
        else
            rdata_out <= 32'h00000000;
    end
endmodule

// ===== tb/mop_protect_props.sv
`timescale 1ns/1ns
module mop_protect_props (
    input wire ref_clk_in,
    input wire nrst_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire torque_limit_out,
    input wire speed_limit_out,
    input wire [7:0] current_cap_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    reg [1:0] up_q;
    reg [7:0] cur_q;
    // Cap still settles for one edge after reset, so hold checks wait
    always @(posedge ref_clk_in)
    begin
        if (!nrst_in)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
        if (wr_in && addr_in == 4'h1 && wdata_in <= 32'h96)
            cur_q <= wdata_in[7:0];
    end
    sequence s_cw;
        wr_in && addr_in == 4'h1 && wdata_in <= 32'h96 ##1 !wr_in;
    endsequence
    sequence s_idle;
        (up_q == 2'h3 && !(wr_in && addr_in == 4'h1)) [*2];
    endsequence
    property p_cap;
        s_cw |-> ##[0:1] current_cap_out == cur_q;
    endproperty
    a_cap: assert property (p_cap) else $error("cap not ref");
    property p_hold;
        s_idle |=> $stable(current_cap_out);
    endproperty
    a_hold: assert property (p_hold) else $error("cap moved");
    property p_mode;
        rd_in && addr_in == 4'h0 |=> rdata_out <= 32'h3;
    endproperty
    a_mode: assert property (p_mode) else $error("bad mode");
    property p_curr;
        rd_in && addr_in == 4'h1 |=> rdata_out <= 32'h96;
    endproperty
    a_curr: assert property (p_curr) else $error("bad ref");
    property p_sens;
        rd_in && addr_in == 4'h4 |=> rdata_out <= 32'h5;
    endproperty
    a_sens: assert property (p_sens) else $error("bad sens");
    property p_cls;
        rd_in && addr_in == 4'h5 |=> rdata_out <= 32'h5;
    endproperty
    a_cls: assert property (p_cls) else $error("bad class");
    property p_chs;
        rd_in && addr_in == 4'h6 |=> rdata_out inside {[32'h1:32'hA]};
    endproperty
    a_chs: assert property (p_chs) else $error("bad chsel");
    property p_excl;
        !(torque_limit_out && speed_limit_out);
    endproperty
    a_excl: assert property (p_excl) else $error("two limits");
endmodule
bind mop_protect mop_protect_props i_props (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .torque_limit_out(torque_limit_out),
    .speed_limit_out(speed_limit_out), .current_cap_out(current_cap_out));

// ===== tb/mop_motor_model.sv
`timescale 1ns/1ns
module mop_motor_model (
    input wire ref_clk_in,
    input wire [7:0] load_in,
    input wire obey_in,
    input wire limit_in,
    input wire [7:0] cap_in,
    output reg [7:0] current_out
);
    // A stuck load ignores the cap, so the drive cannot lower current
    always @(posedge ref_clk_in)
    begin
        if (obey_in && limit_in && load_in > cap_in)
            current_out <= cap_in;
        else
            current_out <= load_in;
    end
endmodule

// ===== tb/mop_protect_tb.sv
`timescale 1ns/1ns
module mop_protect_tb;
    localparam TK = 4;
    localparam [179:0] RV = {72'h0, 12'h190, 12'h0, 12'h7, 12'h3,
        24'h0, 12'h3C, 12'h64, 12'h1};
    reg ref_clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, obey = 1'h1;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0, rv, seed = 32'h29, ev;
    reg [7:0] load = 8'h0;
    reg [1:0] boards = 2'h0, hot = 2'h0;
    reg [47:0] temp = 48'h0;
    reg [15:0] minspd = 16'h0200;
    wire [31:0] rdata;
    wire [7:0] cur, cap;
    wire [15:0] floor;
    wire ovl, trq, spd, thr;
    integer failures = 0, cmp_count = 0, i, k;
    mop_protect #(.TICK_CYC(TK)) i_dut (.ref_clk_in(ref_clk),
        .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .motor_current_in(cur),
        .boards_fitted_in(boards), .thermistor_hot_in(hot),
        .thermometer_temp_in(temp), .minimum_speed_setting_in(minspd),
        .overload_trip_out(ovl), .torque_limit_out(trq),
        .speed_limit_out(spd), .current_cap_out(cap),
        .speed_floor_out(floor), .thermal_trip_out(thr));
    mop_motor_model i_mot (.ref_clk_in(ref_clk), .load_in(load),
        .obey_in(obey), .limit_in(trq | spd), .cap_in(cap),
        .current_out(cur));
    initial forever #10 ref_clk = ~ref_clk;
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
    begin
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xs = y ^ (y << 5);
    end
    endfunction
    // Ticks of full load until the accumulator passes p percent of limit
    function integer tks(input [63:0] c, r, p);
        reg [63:0] l;
    begin
        l = r * r * 144 / 100 * 60000 * p / 100;
        tks = (l + c * c - r * r - 1) / (c * c - r * r);
    end
    endfunction
    function [7:0] lv(input [3:0] c);
        lv = c == 0 ? 100 : c == 1 ? 115 : c == 2 ? 120 : c == 3 ? 140 :
            c == 4 ? 145 : 165;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task cyc(input integer n);
    begin
        repeat (n) @(posedge ref_clk);
        #1;
    end
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
    begin
        @(posedge ref_clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'h0;
        rd <= 1'h0;
        #1 rv = rdata;
    end
    endtask
    task rdc(input [3:0] a, input [31:0] e);
    begin
        bus(1'h0, a, 32'h0);
        chk(rv, e);
    end
    endtask
    task wc(input [3:0] a, input [31:0] d, e);
    begin
        bus(1'h1, a, d);
        rdc(a, e);
    end
    endtask
    task rst;
    begin
        nrst <= 1'h0;
        hot <= 2'h0;
        temp <= 48'h0;
        load <= 8'h0;
        cyc(4);
        nrst <= 1'h1;
        cyc(2);
    end
    endtask
    task th(input [3:0] s, c, m, input [1:0] b, h, input [47:0] tp,
        input e);
    begin
        rst;
        boards <= b;
        cyc(5);
        bus(1'h1, 4'h4, s);
        bus(1'h1, 4'h5, c);
        bus(1'h1, 4'h6, m);
        hot <= h;
        temp <= tp;
        cyc(10);
        chk(thr, e);
    end
    endtask
    // Reference 10 stays above the no-load current of the model
    task ovl_run(input [1:0] m, input ob, input [63:0] p);
    begin
        rst;
        obey <= ob;
        bus(1'h1, 4'h0, m);
        bus(1'h1, 4'h1, 32'hA);
        bus(1'h1, 4'h3, 32'h10);
        load <= 8'hFF;
        cyc((tks(255, 10, p) - 2) * TK);
    end
    endtask
    task test_done;
    begin
        $display("Counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    initial
    begin
        // Roughly three times the expected run of some 7000 cycles
        #(20000 * 20);
        failures = failures + 1;
        test_done;
    end
    initial
    begin
        rst;
        for (i = 0; i < 15; i = i + 1)
            rdc(i[3:0], {20'h0, RV[i*12 +: 12]});
        for (k = 0; k < 4; k = k + 1)
            wc(4'h0, k, k);
        wc(4'h2, 32'h3B, 32'h3C);
        wc(4'h2, 32'h4B0, 32'h4B0);
        wc(4'h2, 32'h4B1, 32'h4B0);
        wc(4'h8, 32'h1F4, 32'h190);
        wc(4'h7, 32'h3, 32'h0);
        wc(4'h7, 32'h1, 32'h1);
        wc(4'h8, 32'h2BC, 32'h2BC);
        wc(4'h8, 32'h63, 32'h2BC);
        wc(4'h8, 32'h64, 32'h64);
        wc(4'h9, 32'h02625A00, 32'h02625A00);
        wc(4'h9, 32'h02625A01, 32'h02625A00);
        wc(4'hA, 32'h00989680, 32'h00989680);
        wc(4'hB, 32'h00989681, 32'h0);
        wc(4'h5, 32'h6, 32'h3);
        wc(4'h6, 32'h0, 32'h7);
        wc(4'h6, 32'hB, 32'h7);
        wc(4'h4, 32'h1, 32'h0);
        boards <= 2'h1;
        cyc(6);
        wc(4'h4, 32'h6, 32'h0);
        wc(4'h4, 32'h5, 32'h5);
        ev = 32'h64;
        for (i = 0; i < 24; i = i + 1)
        begin
            seed = xs(seed);
            k = i < 3 ? 149 + i : seed[7:0];
            if (k <= 150)
                ev = k;
            wc(4'h1, k, ev);
        end
        $display("test registers done");
        for (k = 0; k < 6; k = k + 1)
        begin
            th(2, k, 1, 1, 0, lv(k) - 8'h1, 0);
            th(2, k, 1, 1, 0, lv(k), 1);
        end
        th(2, 3, 1, 1, 0, 48'hFF00, 0);
        th(2, 3, 2, 1, 0, 48'hFF00, 1);
        for (k = 8; k < 11; k = k + 1)
            th(2, 3, k, 1, 0, 48'hFF << (8 * (k - 5)), 1);
        th(2, 3, 8, 1, 0, 48'hFF << 32, 0);
        th(1, 3, 7, 1, 0, 48'hFF, 0);
        th(3, 3, 7, 1, 0, 48'hFF, 0);
        th(1, 3, 7, 2, 2, 48'h0, 0);
        th(1, 3, 7, 2, 1, 48'h0, 1);
        th(4, 3, 7, 2, 2, 48'h0, 1);
        th(0, 3, 7, 1, 3, 48'hFF, 0);
        th(1, 3, 7, 0, 1, 48'h0, 0);
        $display("test sensors done");
        ovl_run(0, 1, 100);
        cyc(200 * TK);
        chk({ovl, trq, spd}, 0);
        chk(floor, 16'h200);
        rdc(4'hD, 0);
        ovl_run(1, 1, 100);
        chk(ovl, 0);
        cyc(5 * TK);
        chk(ovl, 1);
        ovl_run(2, 1, 95);
        chk(trq, 0);
        cyc(5 * TK);
        chk(trq, 1);
        chk(cap, 8'hA);
        cyc(300 * TK);
        chk(ovl, 0);
        ovl_run(2, 0, 110);
        chk(ovl, 0);
        cyc(5 * TK);
        chk(ovl, 1);
        ovl_run(3, 1, 95);
        cyc(5 * TK);
        chk({trq, spd}, 1);
        chk(floor, 16'h10);
        load <= 8'h0;
        bus(1'h1, 4'h1, 32'h96);
        cyc(400 * TK);
        rdc(4'hD, 0);
        chk(spd, 0);
        $display("test overload done");
        test_done;
    end
endmodule
